// [shared/twi_regmap_pkg.sv]
package twi_regmap_pkg;

  localparam int          ADDR_W         = 17;
  localparam int          DATA_W         = 32;
  localparam int          PER_ADDR_W     = 8;
  localparam int          NUM_REGS       = 37;

  localparam logic [16:0] SPACE_LO       = 17'h1D000;
  localparam logic [16:0] SPACE_HI       = 17'h1DFFC;
  localparam logic [16:0] PER_WINDOW     = 17'h1D200;
  localparam logic [16:0] PER_WINDOW_END = 17'h1D2FC;

  // Register indices
  localparam int IDX_REVISION = 0;
  localparam int IDX_SRESET   = 1;
  localparam int IDX_SLV_STAT = 16;

  localparam logic [16:0] REG_OFFSET [NUM_REGS] = '{
    17'h1D100, 17'h1D104, 17'h1D108, 17'h1D10C, 17'h1D110, 17'h1D114,
    17'h1D118, 17'h1D11C, 17'h1D120, 17'h1D124, 17'h1D12C, 17'h1D140,
    17'h1D200, 17'h1D204, 17'h1D210, 17'h1D214, 17'h1D220, 17'h1D224,
    17'h1D280, 17'h1D284, 17'h1D290, 17'h1D294, 17'h1D300, 17'h1D304,
    17'h1D308, 17'h1D30C, 17'h1D320, 17'h1D340, 17'h1D344, 17'h1D348,
    17'h1D34C, 17'h1D350, 17'h1D354, 17'h1D358, 17'h1D35C, 17'h1D3B8,
    17'h1D3BC
  };

  // Writable bits of the registers that are not plain read/write words
  localparam logic [31:0] WMASK_ALL      = 32'hFFFF_FFFF;
  localparam logic [31:0] WMASK_NONE     = 32'h0000_0000;
  localparam logic [31:0] WMASK_SRESET   = 32'h8000_0000;
  localparam int          SRESET_BIT     = 31;
  localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;

  // Slave access status layout: last byte address and direction
  localparam int          STAT_ADDR_LSB  = 0;
  localparam int          STAT_WRITE_BIT = 8;
  localparam int          STAT_VALID_BIT = 9;

  localparam logic [1:0]  LANE_SHIFT_W   = 2'h3;

endpackage : twi_regmap_pkg

// [rtl/twi_regmap.sv]
`timescale 1ns/1ns
module twi_regmap
  import twi_regmap_pkg::*;
#(
  parameter logic [31:0] BLOCK_REVISION = 32'h0000_0005  // Arbitrary value
) (
  input  wire logic                  clk,            // 100 MHz clock
  input  wire logic                  rst,            // Sync reset, active high
  input  wire logic [ADDR_W-1:0]     int_addr,       // Internal byte address
  input  wire logic                  int_wr,         // Internal write strobe
  input  wire logic                  int_rd,         // Internal read strobe
  input  wire logic [DATA_W-1:0]     int_wdata,      // Internal write data
  output logic      [DATA_W-1:0]     int_rdata,      // Internal read data
  output logic                       int_ack,        // Internal access done
  input  wire logic [PER_ADDR_W-1:0] per_addr,       // Peripheral byte address
  input  wire logic                  per_wr,         // Peripheral byte write
  input  wire logic                  per_rd,         // Peripheral byte read
  input  wire logic [7:0]            per_wdata,      // Peripheral write byte
  output logic      [7:0]            per_rdata,      // Peripheral read byte
  output logic                       per_ack,        // Peripheral access done
  output logic                       soft_reset_out  // Soft reset held by software
);

  logic [DATA_W-1:0] reg_q [NUM_REGS];
  logic [DATA_W-1:0] int_or [NUM_REGS+1];
  logic [DATA_W-1:0] per_or [NUM_REGS+1];

  wire               int_sel;
  wire [14:0]        int_word;
  wire [14:0]        per_word;
  wire               soft_rst;
  wire               per_go;
  wire               per_wr_go;
  wire               int_go;
  wire [4:0]         lane_shift;
  wire [DATA_W-1:0]  lane_mask;
  wire [DATA_W-1:0]  per_wide;
  wire [DATA_W-1:0]  per_word_val;
  wire [7:0]         per_byte;

  logic [DATA_W-1:0] int_rdata_reg;
  logic [7:0]        per_rdata_reg;
  logic              int_ack_reg;
  logic              per_ack_reg;

  // Byte bits 1:0 play no part in the decode, so compare whole words only
  assign int_sel  = (int_word >= SPACE_LO[16:2]) && (int_word <= SPACE_HI[16:2]);
  assign int_go   = int_sel && (int_wr || int_rd);
  assign int_word = int_addr[16:2];

  // The peripheral window sits at a fixed internal base, one word per 4 bytes
  assign per_word = PER_WINDOW[16:2] + {9'h000, per_addr[7:2]};

  assign soft_rst       = reg_q[IDX_SRESET][SRESET_BIT];
  assign soft_reset_out = soft_rst;

  // Slave interface is idle while soft reset is held, so the far master
  // gets no acknowledge rather than stale data
  assign per_go    = (per_wr || per_rd) && !soft_rst;
  assign per_wr_go = per_wr && !soft_rst;

  assign lane_shift = {per_addr[1:0], 3'h0};
  assign lane_mask  = 32'h0000_00FF << lane_shift;
  assign per_wide   = {4{per_wdata}};

  assign int_or[0] = RESET_ZERO;
  assign per_or[0] = RESET_ZERO;

  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++) begin : g_reg
      localparam logic [31:0] WMASK =
        (i == IDX_REVISION) ? WMASK_NONE :
        (i == IDX_SRESET)   ? WMASK_SRESET :
        (i == IDX_SLV_STAT) ? WMASK_NONE : WMASK_ALL;
      localparam logic [31:0] RST_VAL =
        (i == IDX_REVISION) ? BLOCK_REVISION : RESET_ZERO;
      localparam bit PER_VIS =
        (REG_OFFSET[i] >= PER_WINDOW) && (REG_OFFSET[i] <= PER_WINDOW_END);

      wire             hit_int;
      wire             hit_per;
      wire [31:0]      wmask_per;
      logic [31:0]     reg_next;

      assign hit_int = int_sel && (int_word == REG_OFFSET[i][16:2]);
      // Only window registers answer to the peripheral side
      assign hit_per = PER_VIS && (per_word == REG_OFFSET[i][16:2]);
      assign wmask_per = WMASK & lane_mask;

      always_comb begin
        reg_next = reg_q[i];
        if (int_wr && hit_int) begin
          reg_next = (reg_next & ~WMASK) | (int_wdata & WMASK);
        end
        // A byte from the far master lands on top of a same-cycle word write
        if (per_wr_go && hit_per) begin
          reg_next = (reg_next & ~wmask_per) | (per_wide & wmask_per);
        end
        if (i == IDX_SLV_STAT) begin
          if (soft_rst) begin
            reg_next = RESET_ZERO;
          end else if (per_wr || per_rd) begin
            reg_next = RESET_ZERO;
            reg_next[STAT_ADDR_LSB +: PER_ADDR_W] = per_addr;
            reg_next[STAT_WRITE_BIT]              = per_wr;
            reg_next[STAT_VALID_BIT]              = 1'b1;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          reg_q[i] <= RST_VAL;
        end else begin
          reg_q[i] <= reg_next;
        end
      end

      // Unmatched and reserved addresses contribute nothing, reading zero
      assign int_or[i+1] = int_or[i] | (hit_int ? reg_q[i] : RESET_ZERO);
      assign per_or[i+1] = per_or[i] | (hit_per ? reg_q[i] : RESET_ZERO);
    end
  endgenerate

  // Peripheral map: 0x00/0x04, 0x10/0x14, 0x80/0x84, 0x90/0x94 and the
  // pair at 0x20/0x24, with the status word at 0x20, fall on the window registers by offset
  assign per_word_val = per_or[NUM_REGS];
  assign per_byte     = 8'((per_word_val >> lane_shift));

  always_ff @(posedge clk) begin
    if (rst) begin
      int_rdata_reg <= RESET_ZERO;
      int_ack_reg   <= 1'b0;
    end else begin
      int_ack_reg <= int_go;
      if (int_rd && !int_wr && int_sel) begin
        int_rdata_reg <= int_or[NUM_REGS];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      per_rdata_reg <= 8'h00;
      per_ack_reg   <= 1'b0;
    end else begin
      per_ack_reg <= per_go;
      if (per_rd && !per_wr && !soft_rst) begin
        per_rdata_reg <= per_byte;
      end
    end
  end

  assign int_rdata = int_rdata_reg;
  assign int_ack   = int_ack_reg;
  assign per_rdata = per_rdata_reg;
  assign per_ack   = per_ack_reg;

endmodule : twi_regmap

// [tb/twi_regmap_monitor.sv]
`timescale 1ns/1ns
module twi_regmap_monitor
  import twi_regmap_pkg::*;
(
  input wire logic                  clk, rst, int_wr, int_rd, int_ack, per_wr, per_rd,
  input wire logic                  per_ack, soft_reset_out,
  input wire logic [ADDR_W-1:0]     int_addr,
  input wire logic [DATA_W-1:0]     int_wdata, int_rdata,
  input wire logic [PER_ADDR_W-1:0] per_addr,
  input wire logic [7:0]            per_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic in_rng = int_addr[16:12] == 5'h1D;
  wire logic per_go = (per_wr | per_rd) & !soft_reset_out;
  sequence s_box_wr; int_wr && int_addr == 17'h1D294 && !per_wr; endsequence
  sequence s_lane_rd; per_rd && !per_wr && per_addr == 8'h95 && !soft_reset_out; endsequence
  property p_ack; (int_wr || int_rd) && in_rng |=> int_ack; endproperty
  property p_no_ack; (int_wr || int_rd) && !in_rng |=> !int_ack; endproperty
  property p_wr_rd; int_wr && int_addr == 17'h1D3BC ##1 int_rd && !int_wr && int_addr == 17'h1D3BC
    |=> int_rdata == $past(int_wdata, 2); endproperty
  property p_rsv; int_rd && !int_wr && int_addr[16:8] == 9'h1D0 |=> int_rdata == 32'h0; endproperty
  property p_per_ack; per_go |=> per_ack; endproperty
  property p_per_off; (per_wr || per_rd) && soft_reset_out |=> !per_ack; endproperty
  property p_lane; s_box_wr ##1 s_lane_rd |=> per_rdata == $past(int_wdata[15:8], 2); endproperty
  property p_per_rsv; per_go && per_rd && !per_wr && per_addr inside {[8'h28:8'h7F]}
    |=> per_rdata == 8'h0; endproperty
  a_ack: assert property (p_ack) else $error("access in range not acked");
  a_no_ack: assert property (p_no_ack) else $error("access out of range acked");
  a_wr_rd: assert property (p_wr_rd) else $error("word readback wrong");
  a_rsv: assert property (p_rsv) else $error("reserved word not zero");
  a_per_ack: assert property (p_per_ack) else $error("byte access not acked");
  a_per_off: assert property (p_per_off) else $error("byte acked in soft reset");
  a_lane: assert property (p_lane) else $error("byte lane wrong");
  a_per_rsv: assert property (p_per_rsv) else $error("reserved byte not zero");
endmodule : twi_regmap_monitor
bind twi_regmap twi_regmap_monitor mon (.clk, .rst, .int_wr, .int_rd, .int_ack, .per_wr,
  .per_rd, .per_ack, .soft_reset_out, .int_addr, .int_wdata, .int_rdata, .per_addr, .per_rdata);

// [tb/twi_ext_master_model.sv]
`timescale 1ns/1ns
module twi_ext_master_model (
  output logic       per_wr    = 1'b0, // Byte write strobe
  output logic       per_rd    = 1'b0, // Byte read strobe
  output logic [7:0] per_addr  = 8'h00, // Byte address
  output logic [7:0] per_wdata = 8'h00  // Byte to write
);
  // Released address and data lines invert, strobes drop low, so a stale byte can never pass for a fresh one
  task automatic put(input logic go, w, input logic [7:0] a, d);
    per_wr = go & w;
    per_rd = go & !w;
    per_addr = go ? a : ~per_addr;
    per_wdata = go ? d : ~per_wdata;
  endtask : put
endmodule : twi_ext_master_model

// [tb/test_i2c_register_window_map.sv]
`timescale 1ns/1ns
module test_i2c_register_window_map;
  import twi_regmap_pkg::*;
  localparam logic [31:0] REV = 32'h0000_00A3; // Arbitrary value
  logic clk = 0, rst = 1, int_wr = 0, int_rd = 0, int_ack, per_ack, soft_reset_out, per_wr, per_rd;
  logic [16:0] int_addr = 17'h0;
  logic [31:0] int_wdata = 32'h0, int_rdata, d, v[NUM_REGS], pv[9];
  logic [7:0]  per_addr, per_wdata, per_rdata, w8;
  logic [7:0]  pw[9] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h24, 8'h80, 8'h84, 8'h90, 8'h94};
  logic [32:0] iq[$], pq[$];
  integer      seed = 32'hAA6C48F1, errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  twi_ext_master_model ext (.per_wr, .per_rd, .per_addr, .per_wdata);
  twi_regmap #(.BLOCK_REVISION(REV)) uut (.clk, .rst, .int_addr, .int_wr, .int_rd, .int_wdata,
    .int_rdata, .int_ack, .per_addr, .per_wr, .per_rd, .per_wdata, .per_rdata, .per_ack,
    .soft_reset_out);
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // One access per cycle; ack means a note is queued, the value only matters on reads
  task automatic op(input logic ps, w, ack, input logic [16:0] a, input logic [31:0] dd, e);
    int_wr = !ps & w;
    int_rd = !ps & !w;
    int_addr = a;
    int_wdata = dd;
    ext.put(ps, w, a[7:0], dd[7:0]);
    if (ack && ps) pq.push_back({w, 24'h0, e[7:0]});
    else if (ack) iq.push_back({w, e});
    @(negedge clk);
  endtask : op
  task automatic chk(ref logic [32:0] q[$], input logic [31:0] s, input string n);
    logic [32:0] t;
    comparisons++;
    if (q.size() == 0) begin
      errors++;
      $display("FAIL %s expected no ack seen ack", n);
    end else begin
      t = q.pop_front();
      if (!t[32] && s !== t[31:0]) begin
        errors++;
        $display("FAIL %s expected %h seen %h", n, t[31:0], s);
      end
    end
  endtask : chk
  always @(negedge clk) begin
    if (int_ack === 1'b1) chk(iq, int_rdata, "int_rdata");
    if (per_ack === 1'b1) chk(pq, {24'h0, per_rdata}, "per_rdata");
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    @(negedge clk);
    for (int i = 0; i < NUM_REGS; i++) begin
      v[i] = $random(seed);
      op(0, 1, 1, REG_OFFSET[i], v[i] & (i == IDX_SRESET ? ~WMASK_SRESET : WMASK_ALL), 0);
    end
    for (int i = 0; i < NUM_REGS; i++) op(0, 0, 1, REG_OFFSET[i], 0, i == IDX_REVISION ? REV
      : (i == IDX_SRESET || i == IDX_SLV_STAT) ? 32'h0 : v[i]);
    $display("register readback done");
    d = $random(seed);
    op(0, 1, 1, 17'h1D3BC, d, 0);
    op(0, 0, 1, 17'h1D3BC, 0, d);
    op(0, 1, 1, 17'h1D000, $random(seed), 0);
    op(0, 0, 1, 17'h1D000, 0, 0);
    op(0, 0, 0, 17'h1E000, 0, 0);
    for (int r = 0; r < 9; r++) begin
      for (int b = 0; b < 4; b++) begin
        w8 = $random(seed);
        pv[r][8*b +: 8] = w8;
        op(1, 1, 1, {9'h1D2, pw[r] + 8'(b)}, {24'h0, w8}, 0);
      end
      op(0, 0, 1, PER_WINDOW + 17'(pw[r]), 0, pv[r]);
    end
    op(0, 0, 1, REG_OFFSET[2], 0, v[2]);
    foreach (pw[k]) op(1, 1, 1, {9'h1D2, pw[k] + 8'h08}, $random(seed), 0);
    foreach (pw[k]) op(1, 0, 1, {9'h1D2, pw[k] + 8'h08}, 0, 0);
    op(1, 0, 1, 17'h1D228, 0, 0);
    $display("byte window done");
    d = $random(seed);
    op(0, 1, 1, 17'h1D294, d, 0);
    for (int b = 1; b < 5; b++) op(1, 0, 1, {15'h74A5, 2'(b)}, 0, d >> (8 * (b % 4)));
    op(0, 0, 1, 17'h1D220, 0, 32'h0000_0294);
    op(0, 1, 1, 17'h1D104, 32'hFFFF_FFFF, 0);
    op(1, 1, 0, 17'h1D290, 32'h5A, 0);
    op(0, 0, 1, 17'h1D104, 0, 32'h8000_0000);
    comparisons++;
    if (soft_reset_out !== 1'b1) begin
      errors++;
      $display("FAIL soft_reset_out expected 1 seen %b", soft_reset_out);
    end
    op(0, 0, 1, 17'h1D220, 0, 0);
    op(0, 1, 1, 17'h1D104, 0, 0);
    op(1, 0, 1, 17'h1D290, 0, pv[7]);
    op(0, 0, 1, 17'h1D294, 0, d);
    repeat (3) op(0, 0, 0, 17'h0, 0, 0);
    if (iq.size() + pq.size() != 0) begin
      errors++;
      $display("FAIL queue expected 0 seen %0d", iq.size() + pq.size());
    end
    $display("soft reset done");
    report_and_stop();
  end
  // About 160 accesses are planned; over twelve times that bounds a hang
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule : test_i2c_register_window_map
